// File: dv/crl_host.sv
// host calibration station model: single-wire serial transmitter
`timescale 1ns/1ps
module crl_host (
    // clock
    input  wire logic i_sys_clk,
    // serial line
    output logic      o_pin
);
    // the line starts high at idle, so no false start
    initial o_pin = 1'b1;
    // bit time in clocks; caller keeps it inside the learnable range
    task automatic send(input logic [7:0] data, input int bitc);
        logic [9:0] frame;
        frame = {1'b1, data, 1'b0};
        for (int i = 0; i < 10; i++) begin
            repeat (bitc) @(posedge i_sys_clk);
            o_pin <= frame[i];
        end
        repeat (bitc) @(posedge i_sys_clk);
    endtask
endmodule

// File: dv/crl_loader_tb.sv
// self-checking bench of the calibration register loader
`timescale 1ns/1ps
module crl_loader_tb;
    logic              i_sys_clk = 1'b0;
    logic              i_rstn;
    logic              i_unlock;
    logic              i_wr;
    logic              i_rd;
    logic              rd_d = 1'b0;
    logic              pin;
    logic [7:0]        i_temp_code;
    logic [7:0]        b1;
    logic [7:0]        b2;
    logic [3:0]        i_addr;
    logic [15:0]       i_wdata;
    logic [15:0]       o_rdata;
    logic [7:0]        o_temp_index;
    logic              o_unlocked;
    crl_pkg::crl_cal_s o_cal;
    logic              o_unlocked_lk;
    crl_pkg::crl_cal_s o_cal_lk;
    logic [15:0]       exp_q[$];
    int                n_errors = 0;
    int                compares = 0;
    int                seed = 32'hf0fdab13;
    always #2.5 i_sys_clk = ~i_sys_clk;
    crl_host u_host (.i_sys_clk(i_sys_clk), .o_pin(pin));
    // short refresh and tick so the run stays brief
    crl_loader #(.REFRESH_CYC(40), .TICK_CYC(4)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_single_wire_pin(pin), .i_unlock(i_unlock),
        .i_temp_code(i_temp_code), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_cal(o_cal), .o_temp_index(o_temp_index), .o_unlocked(o_unlocked));
    // same bus and pin but shipped locked, so the memory path and the override are seen
    crl_loader #(.REFRESH_CYC(40), .TICK_CYC(4), .LOCK_INIT(8'hff), .OSC_TRIM(3'h5)) u_dut_lk (
        .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_single_wire_pin(pin), .i_unlock(i_unlock),
        .i_temp_code(i_temp_code), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(), .o_cal(o_cal_lk), .o_temp_index(), .o_unlocked(o_unlocked_lk));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge i_sys_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd   <= 1'b0;
    endtask
    // command 14 writes span trim with low byte first
    task automatic cal_span(input int bitc);
        b1 = 8'($random(seed));
        b2 = 8'($random(seed));
        u_host.send(8'h14, bitc);
        u_host.send(b1, bitc);
        u_host.send(b2, bitc);
        repeat (20) @(posedge i_sys_clk);
        check("span trim", {b2, b1}, o_cal.span_trim_reg);
        rd(4'h4, {b2, b1});
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge i_sys_clk) begin
        if (rd_d)
            check("read data", exp_q.pop_front(), o_rdata);
        rd_d <= i_rd;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rstn      = 1'b0;
        i_unlock    = 1'b0;
        i_wr        = 1'b0;
        i_rd        = 1'b0;
        i_addr      = 4'h0;
        i_wdata     = 16'h0000;
        i_temp_code = 8'h41;
        repeat (20) @(posedge i_sys_clk);
        i_rstn      <= 1'b1;
        i_temp_code <= 8'($random(seed));
        // locked refresh needs about fourteen cycles after release
        repeat (20) @(posedge i_sys_clk);
        check("unlocked", 16'h0001, 16'(o_unlocked));
        check("locked pin", 16'h0000, 16'(o_unlocked_lk));
        check("setup word", 16'hfffd, o_cal_lk.config_word);
        check("offset trim", 16'hffff, o_cal_lk.offset_trim_reg);
        // forty ticks per bit keeps the sampling drift over a frame small
        u_host.send(8'h01, 160);
        cal_span(160);
        check("locked span", 16'hffff, o_cal_lk.span_trim_reg);
        rd(4'h5, {8'h0c, ((i_temp_code > 8'haf) ? 8'haf : i_temp_code)});
        @(posedge i_sys_clk);
        i_wr    <= 1'b1;
        i_addr  <= 4'h7;
        i_wdata <= 16'h0001;
        @(posedge i_sys_clk);
        i_wr    <= 1'b0;
        // a refresh here would clobber the serial value
        repeat (60) @(posedge i_sys_clk);
        rd(4'h4, {b2, b1});
        rd(4'h8, 16'h0000);
        u_host.send(8'hff, 160);
        i_unlock    <= 1'b1;
        i_temp_code <= 8'($random(seed)) | 8'hb0;
        u_host.send(8'h01, 240);
        cal_span(240);
        check("override span", {b2, b1}, o_cal_lk.span_trim_reg);
        rd(4'h5, {8'h0c, 8'haf});
        check("temp index", 16'h00af, 16'(o_temp_index));
        // memory write of the setup word low byte: trim bits must survive
        u_host.send(8'h21, 240);
        u_host.send(8'h60, 240);
        u_host.send(8'h00, 240);
        i_unlock <= 1'b0;
        repeat (60) @(posedge i_sys_clk);
        check("kept trim", 16'hff05, o_cal_lk.config_word);
        check("refreshed span", 16'hffff, o_cal_lk.span_trim_reg);
        repeat (5) @(posedge i_sys_clk);
        end_of_test;
    end
    initial begin
        #200000;
        n_errors++;
        end_of_test;
    end
endmodule

// File: rtl/crl_defs.svh
// constants of the calibration register loader
`ifndef CRL_DEFS_SVH
`define CRL_DEFS_SVH
`define CRL_CLK_HZ          200000000
`define CRL_REFRESH_NS      1000000
`define CRL_REFRESH_CYC     ((`CRL_REFRESH_NS / 1000) * (`CRL_CLK_HZ / 1000000))
`define CRL_TICK_CYC        256
`define CRL_MEM_BYTES       768
`define CRL_PAGE_BYTES      64
`define CRL_PAGES           12
`define CRL_NUM_CAL         5
`define CRL_IRS_DEPTH       16
`define CRL_ERASED          8'hff
`define CRL_LOCK_SET        8'hff
`define CRL_LOCK_OPEN       8'h00
`define CRL_INIT_CHAR       8'h01
`define CRL_REINIT_CHAR     8'hff
`define CRL_TEMP_MAX        8'haf
`define CRL_TEMP_SPLIT      8'h80
`define CRL_ADDR_CONFIG     10'h160
`define CRL_ADDR_OTC        10'h164
`define CRL_ADDR_STC        10'h168
`define CRL_ADDR_LOCK       10'h16a
`define CRL_ADDR_OFS_BASE   10'h000
`define CRL_ADDR_SPAN_LO    10'h200
`define CRL_ADDR_SPAN_HI    10'h1a0
`define CRL_OSC_MASK        8'h07
`define CRL_OP_CAL          4'h1
`define CRL_OP_MEM          4'h2
`define CRL_RA_STATUS       4'h5
`define CRL_RA_BITPER       4'h6
`define CRL_RA_CTRL         4'h7
`endif

// File: rtl/crl_loader.sv
// calibration register loader: memory refresh, serial calibration link, register port
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "crl_defs.svh"
module crl_loader #(
    parameter int REFRESH_CYC = `CRL_REFRESH_CYC,
    parameter int TICK_CYC    = `CRL_TICK_CYC,
    parameter logic [7:0] LOCK_INIT = `CRL_LOCK_OPEN,
    parameter logic [2:0] OSC_TRIM  = 3'h4
) (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rstn,
    // pins
    input  wire logic              i_single_wire_pin,
    input  wire logic              i_unlock,
    input  wire logic [7:0]        i_temp_code,
    // register port
    input  wire logic [3:0]        i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [15:0]            o_rdata,
    // calibration outputs
    output crl_pkg::crl_cal_s      o_cal,
    output logic [7:0]             o_temp_index,
    output logic                   o_unlocked
);
    ////////////////////////////////////////////////////////////////////////////
    if (REFRESH_CYC < 4 || TICK_CYC < 2 || TICK_CYC > 65536) begin : g_chk
        $error("crl_loader: unsupported timing parameters");
    end

    logic [7:0]         mem [`CRL_MEM_BYTES];
    logic [7:0]         mem_rd;
    logic [9:0]         rd_addr;
    logic               mem_we;
    logic [9:0]         mem_wa;
    logic [7:0]         mem_wd;
    logic [15:0]        cal [`CRL_NUM_CAL];
    logic [15:0]        hold_latch;
    logic [7:0]         lock_code;
    logic               locked;
    logic               serial_ok;
    crl_pkg::crl_rf_e   rf_state;
    logic [3:0]         step;
    logic [3:0]         data_step;
    logic               data_vld;
    logic [31:0]        ms_cnt;
    logic               ms_pulse;
    logic               sw_refresh;
    logic [15:0]        tick_cnt;
    logic               tick;
    crl_pkg::crl_rx_e   rx_state;
    logic               pin_q;
    logic [7:0]         bit_period_count;
    logic               rate_known;
    logic [7:0]         tcnt;
    logic [2:0]         bitn;
    logic [7:0]         shreg;
    logic               byte_vld;
    logic [7:0]         command_register_set [`CRL_IRS_DEPTH];
    logic [3:0]         irs_ptr;
    logic [1:0]         grp;
    logic               ser_cal_we;

    assign locked    = (lock_code == `CRL_LOCK_SET) && !i_unlock;
    assign serial_ok = (lock_code == `CRL_LOCK_OPEN) || i_unlock;
    assign o_unlocked = serial_ok;

    ////////////////////////////////////////////////////////////////////////////
    // memory: 768 bytes, twelve erasable 64-byte pages (erase is a page of FF writes)
    initial begin
        for (int i = 0; i < `CRL_MEM_BYTES; i++) begin
            mem[i] = `CRL_ERASED;
        end
        mem[`CRL_ADDR_CONFIG] = {5'h1f, OSC_TRIM};
        mem[`CRL_ADDR_LOCK]   = LOCK_INIT;
    end

    // plain always: the initial block above also writes this array
    always @(posedge i_sys_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
        mem_rd <= mem[rd_addr];
    end

    ////////////////////////////////////////////////////////////////////////////
    // millisecond timer and temperature index
    assign ms_pulse = (ms_cnt == 32'(REFRESH_CYC - 1));
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ms_cnt <= '0;
        end else begin
            ms_cnt <= ms_pulse ? '0 : ms_cnt + 32'h1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_temp_index <= 8'h00;
        end else if (ms_pulse) begin
            // clamp so hot readings never wrap onto cold entries
            o_temp_index <= (i_temp_code > `CRL_TEMP_MAX) ? `CRL_TEMP_MAX : i_temp_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // refresh sequencer: steps 0..9 read low then high byte of five words
    function automatic logic [9:0] step_addr(input logic [3:0] s, input logic [7:0] ti);
        logic [9:0] base;
        base = 10'h000;
        unique case (s[3:1])
            3'h0: base = `CRL_ADDR_CONFIG;
            3'h1: base = `CRL_ADDR_OTC;
            3'h2: base = `CRL_ADDR_STC;
            3'h3: base = `CRL_ADDR_OFS_BASE + {1'b0, ti, 1'b0};
            3'h4: base = (ti < `CRL_TEMP_SPLIT) ? `CRL_ADDR_SPAN_LO + {1'b0, ti, 1'b0}
                       : `CRL_ADDR_SPAN_HI + {1'b0, ti - `CRL_TEMP_SPLIT, 1'b0};
            default: base = `CRL_ADDR_LOCK;
        endcase
        return base + {9'h000, s[0]};
    endfunction

    assign rd_addr = (rf_state == crl_pkg::RF_RUN) ? step_addr(step, o_temp_index) : `CRL_ADDR_LOCK;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rf_state <= crl_pkg::RF_BOOT;
            step     <= 4'h0;
        end else begin
            unique case (rf_state)
                crl_pkg::RF_BOOT: rf_state <= crl_pkg::RF_LOCK;
                crl_pkg::RF_LOCK: rf_state <= crl_pkg::RF_IDLE;
                crl_pkg::RF_IDLE: begin
                    // serial mode keeps written values: no refresh while unlocked
                    if (locked && (ms_pulse || sw_refresh || step == 4'hf)) begin
                        rf_state <= crl_pkg::RF_RUN;
                    end
                    step <= 4'h0;
                end
                crl_pkg::RF_RUN: begin
                    if (step == 4'h9) begin
                        rf_state <= crl_pkg::RF_IDLE;
                        step     <= 4'he;
                    end else begin
                        step <= step + 4'h1;
                    end
                end
            endcase
            if (rf_state == crl_pkg::RF_LOCK) begin
                step <= 4'hf;   // marks first pass after reset
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            data_vld  <= 1'b0;
            data_step <= 4'h0;
            lock_code <= `CRL_LOCK_SET;
        end else begin
            data_vld  <= (rf_state == crl_pkg::RF_RUN);
            data_step <= step;
            if (rf_state == crl_pkg::RF_LOCK) begin
                lock_code <= mem_rd;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // holding latch and calibration registers
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hold_latch <= 16'h0000;
        end else if (data_vld) begin
            if (data_step[0]) begin
                hold_latch[15:8] <= mem_rd;
            end else begin
                hold_latch[7:0] <= mem_rd;
            end
        end else if (byte_vld && grp != 2'h0) begin
            if (grp == 2'h1) begin
                hold_latch[7:0] <= shreg;
            end else begin
                hold_latch[15:8] <= shreg;
            end
        end
    end

    assign ser_cal_we = byte_vld && grp == 2'h2 && serial_ok
                      && command_register_set[irs_ptr - 4'h2][7:4] == `CRL_OP_CAL;

    for (genvar g = 0; g < `CRL_NUM_CAL; g++) begin : g_cal
        always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                cal[g] <= 16'h0000;
            end else if (data_vld && data_step[0] && data_step[3:1] == 3'(g)) begin
                cal[g] <= {mem_rd, hold_latch[7:0]};
            end else if (ser_cal_we && command_register_set[irs_ptr - 4'h2][2:0] == 3'(g)) begin
                cal[g] <= {shreg, hold_latch[7:0]};
            end
        end
    end
    assign o_cal = '{cal[0], cal[1], cal[2], cal[3], cal[4]};

    // memory write: cmd, address low byte, data; trim bits of the setup word are kept
    always_comb begin
        mem_wa = {command_register_set[irs_ptr - 4'h2][1:0], hold_latch[7:0]};
        mem_we = byte_vld && grp == 2'h2 && serial_ok
               && command_register_set[irs_ptr - 4'h2][7:4] == `CRL_OP_MEM;
        mem_wd = shreg;
        if (mem_wa == `CRL_ADDR_CONFIG) begin
            mem_wd = (shreg & ~`CRL_OSC_MASK) | (mem[`CRL_ADDR_CONFIG] & `CRL_OSC_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial receiver, timed in ticks of TICK_CYC clocks so the period fits 8 bits
    assign tick = (tick_cnt == 16'(TICK_CYC - 1));
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tick_cnt <= 16'h0000;
            pin_q    <= 1'b1;
        end else begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h1;
            pin_q    <= i_single_wire_pin;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_state         <= crl_pkg::RX_SYNC;
            bit_period_count <= 8'h00;
            rate_known       <= 1'b0;
            tcnt             <= 8'h00;
            bitn             <= 3'h0;
            shreg            <= 8'h00;
            byte_vld         <= 1'b0;
        end else begin
            byte_vld <= 1'b0;
            if (!serial_ok) begin
                rx_state   <= crl_pkg::RX_SYNC;
                rate_known <= 1'b0;
            end else begin
                unique case (rx_state)
                    crl_pkg::RX_SYNC: begin
                        tcnt <= 8'h00;
                        if (pin_q && !i_single_wire_pin) begin
                            rx_state <= crl_pkg::RX_MEAS;
                        end
                    end
                    crl_pkg::RX_MEAS: begin
                        if (i_single_wire_pin) begin
                            bit_period_count <= (tcnt == 8'h00) ? 8'h01 : tcnt;
                            rate_known <= 1'b1;
                            tcnt       <= 8'h00;
                            bitn       <= 3'h0;
                            rx_state   <= crl_pkg::RX_SKIP;
                        end else if (tick && tcnt != 8'hff) begin
                            tcnt <= tcnt + 8'h1;
                        end
                    end
                    crl_pkg::RX_SKIP: begin
                        // let the data bits of the sync character pass: eight bits
                        if (tick) begin
                            if (tcnt == bit_period_count - 8'h1) begin
                                tcnt <= 8'h00;
                                bitn <= bitn + 3'h1;
                                if (bitn == 3'h7) begin
                                    rx_state <= crl_pkg::RX_IDLE;
                                end
                            end else begin
                                tcnt <= tcnt + 8'h1;
                            end
                        end
                    end
                    crl_pkg::RX_IDLE: begin
                        tcnt <= 8'h00;
                        bitn <= 3'h0;
                        if (pin_q && !i_single_wire_pin) begin
                            rx_state <= crl_pkg::RX_START;
                        end
                    end
                    crl_pkg::RX_START: begin
                        if (tick) begin
                            if (tcnt >= {1'b0, bit_period_count[7:1]}) begin
                                tcnt     <= 8'h00;
                                rx_state <= i_single_wire_pin ? crl_pkg::RX_IDLE : crl_pkg::RX_DATA;
                            end else begin
                                tcnt <= tcnt + 8'h1;
                            end
                        end
                    end
                    crl_pkg::RX_DATA: begin
                        if (tick) begin
                            if (tcnt == bit_period_count - 8'h1) begin
                                tcnt  <= 8'h00;
                                shreg <= {i_single_wire_pin, shreg[7:1]};
                                bitn  <= bitn + 3'h1;
                                if (bitn == 3'h7) begin
                                    rx_state <= crl_pkg::RX_STOP;
                                end
                            end else begin
                                tcnt <= tcnt + 8'h1;
                            end
                        end
                    end
                    crl_pkg::RX_STOP: begin
                        if (tick) begin
                            if (tcnt == bit_period_count - 8'h1) begin
                                byte_vld <= i_single_wire_pin;
                                rx_state <= crl_pkg::RX_IDLE;
                                if (i_single_wire_pin && grp == 2'h0 && shreg == `CRL_REINIT_CHAR) begin
                                    byte_vld   <= 1'b0;
                                    rate_known <= 1'b0;
                                    rx_state   <= crl_pkg::RX_SYNC;
                                end
                            end else begin
                                tcnt <= tcnt + 8'h1;
                            end
                        end
                    end
                    default: rx_state <= crl_pkg::RX_SYNC;
                endcase
            end
        end
    end

    // command register set: every byte but the sync and reinit characters lands here, three bytes make one command
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            irs_ptr <= 4'h0;
            grp     <= 2'h0;
        end else if (rx_state == crl_pkg::RX_SYNC) begin
            grp <= 2'h0;
        end else if (byte_vld) begin
            irs_ptr <= irs_ptr + 4'h1;
            grp     <= (grp == 2'h2) ? 2'h0 : grp + 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (byte_vld) begin
            command_register_set[irs_ptr] <= shreg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register port
    assign sw_refresh = i_wr && i_addr == `CRL_RA_CTRL && i_wdata[0];
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            if (i_addr < 4'(`CRL_NUM_CAL)) begin
                o_rdata <= cal[3'(i_addr)];
            end else if (i_addr == `CRL_RA_STATUS) begin
                o_rdata <= {4'h0, rate_known, serial_ok, locked, 1'b0, o_temp_index};
            end else if (i_addr == `CRL_RA_BITPER) begin
                o_rdata <= {lock_code, bit_period_count};
            end else begin
                o_rdata <= 16'h0000;
            end
        end else begin
            o_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_refresh_walk;
        (rf_state == crl_pkg::RF_RUN) [*8] ##1 (rf_state == crl_pkg::RF_RUN) ##1 (rf_state == crl_pkg::RF_RUN);
    endsequence

    property p_clamp;
        @(posedge i_sys_clk) disable iff (!i_rstn) o_temp_index <= `CRL_TEMP_MAX;
    endproperty
    a_clamp: assert property (p_clamp) else $error("temperature index above clamp");

    property p_ms_refresh;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            (ms_pulse && locked && rf_state == crl_pkg::RF_IDLE) |=> s_refresh_walk ##1 (rf_state == crl_pkg::RF_IDLE);
    endproperty
    a_ms_refresh: assert property (p_ms_refresh) else $error("millisecond refresh not ten steps");

    property p_no_refresh_unlocked;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            (serial_ok && rf_state == crl_pkg::RF_IDLE) |=> rf_state != crl_pkg::RF_RUN;
    endproperty
    a_no_refresh_unlocked: assert property (p_no_refresh_unlocked) else $error("refresh while unlocked");

    property p_span_addr;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            (rf_state == crl_pkg::RF_RUN && step == 4'h8) |-> (rd_addr == ((o_temp_index < 8'h80)
            ? 10'h200 + {1'b0, o_temp_index, 1'b0} : 10'h1a0 + {1'b0, o_temp_index - 8'h80, 1'b0}));
    endproperty
    a_span_addr: assert property (p_span_addr) else $error("span table address wrong");

    property p_ofs_addr;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            (rf_state == crl_pkg::RF_RUN && step == 4'h7) |-> rd_addr == {1'b0, o_temp_index, 1'b1};
    endproperty
    a_ofs_addr: assert property (p_ofs_addr) else $error("offset table address wrong");

    property p_word_pair;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            (data_vld && data_step == 4'h1) |=> cal[0] == {$past(mem_rd), $past(hold_latch[7:0])};
    endproperty
    a_word_pair: assert property (p_word_pair) else $error("setup word not assembled");

    property p_locked_ignore;
        @(posedge i_sys_clk) disable iff (!i_rstn) !serial_ok |=> (rx_state == crl_pkg::RX_SYNC && !byte_vld);
    endproperty
    a_locked_ignore: assert property (p_locked_ignore) else $error("traffic accepted while locked");

    property p_irs_store;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            byte_vld |=> command_register_set[$past(irs_ptr)] == $past(shreg) && irs_ptr == $past(irs_ptr) + 4'h1;
    endproperty
    a_irs_store: assert property (p_irs_store) else $error("byte not stored in command set");

    property p_meas;
        @(posedge i_sys_clk) disable iff (!i_rstn)
            (rx_state == crl_pkg::RX_MEAS && serial_ok && i_single_wire_pin)
            |=> (rate_known && rx_state == crl_pkg::RX_SKIP && bit_period_count != 8'h00);
    endproperty
    a_meas: assert property (p_meas) else $error("bit period not captured");
endmodule

// File: rtl/crl_pkg.sv
// types of the calibration register loader
package crl_pkg;
    typedef enum logic [2:0] {
        RX_SYNC  = 3'b000,
        RX_MEAS  = 3'b001,
        RX_SKIP  = 3'b010,
        RX_IDLE  = 3'b011,
        RX_START = 3'b100,
        RX_DATA  = 3'b101,
        RX_STOP  = 3'b110
    } crl_rx_e;
    typedef enum logic [1:0] {
        RF_BOOT = 2'b00,
        RF_LOCK = 2'b01,
        RF_IDLE = 2'b10,
        RF_RUN  = 2'b11
    } crl_rf_e;
    typedef struct packed {
        logic [15:0] config_word;
        logic [15:0] offset_tempco_reg;
        logic [15:0] span_tempco_reg;
        logic [15:0] offset_trim_reg;
        logic [15:0] span_trim_reg;
    } crl_cal_s;
endpackage
